/* shared/hgp_params.svh */
// Register map, field positions and reset values of the pin control unit
`ifndef HGP_PARAMS_SVH
`define HGP_PARAMS_SVH

`define HGP_OFS_PIN_STS 8'h0e
`define HGP_OFS_INPUT_EN 8'h0f
`define HGP_OFS_PIN0_CTL 8'h10

`define HGP_RST_PIN_STS 8'h00
`define HGP_RST_INPUT_EN 8'hff
`define HGP_RST_PIN0_CTL 8'h00
`define HGP_RD_IDLE 8'h00

`define HGP_CTL_EN_BIT 0
`define HGP_CTL_VAL_BIT 1
`define HGP_CTL_SRC_LSB 2
`define HGP_CTL_SRC_MSB 4
`define HGP_CTL_SEL_LSB 5
`define HGP_CTL_SEL_MSB 7

`endif

/* shared/hgp_pkg.sv */
// Types shared by the pin control unit and its output selector
`default_nettype none
package hgp_pkg;

  typedef enum logic [2:0] {
    hgp_src_rx0 = 3'h0,
    hgp_src_rx1 = 3'h1,
    hgp_src_rx2 = 3'h2,
    hgp_src_rx3 = 3'h3,
    hgp_src_dev = 3'h4,
    hgp_src_rsvd = 3'h5,
    hgp_src_tx0 = 3'h6,
    hgp_src_tx1 = 3'h7
  } hgp_src_e;

  typedef enum logic [2:0] {
    hgp_rx_gpio0 = 3'h0,
    hgp_rx_gpio1 = 3'h1,
    hgp_rx_gpio2 = 3'h2,
    hgp_rx_gpio3 = 3'h3,
    hgp_rx_lock = 3'h4,
    hgp_rx_pass = 3'h5,
    hgp_rx_fv = 3'h6,
    hgp_rx_lv = 3'h7
  } hgp_rx_sel_e;

  typedef enum logic [2:0] {
    hgp_dev_value = 3'h0,
    hgp_dev_lock_or = 3'h1,
    hgp_dev_lock_and = 3'h2,
    hgp_dev_pass_and = 3'h3,
    hgp_dev_pass_or = 3'h4
  } hgp_dev_sel_e;

  typedef enum logic [2:0] {
    hgp_tx_pass_and = 3'h0,
    hgp_tx_pass_or = 3'h1,
    hgp_tx_fv = 3'h2,
    hgp_tx_lv = 3'h3,
    hgp_tx_synced = 3'h4,
    hgp_tx_irq = 3'h5
  } hgp_tx_sel_e;

  typedef struct packed {
    logic [3:0] remote_gpio;
    logic lock;
    logic pass;
    logic frame_valid;
    logic line_valid;
  } hgp_rx_port_s;

  typedef struct packed {
    logic [3:0] rx_map;
    logic frame_valid;
    logic line_valid;
    logic synced;
    logic irq;
  } hgp_tx_port_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hgp_reg_req_s;

endpackage

`default_nettype wire

/* sim/hgp_board_model.sv */
// Board-side model: pin levels, receive and transmit port status
`timescale 1ns/100ps
`default_nettype none
module hgp_board_model (
  input wire logic clk,
  input wire logic upd,
  output var logic [7:0] gpio_in,
  output var hgp_pkg::hgp_rx_port_s [3:0] rx_status,
  output var logic [3:0] rx_port_en,
  output var hgp_pkg::hgp_tx_port_s [1:0] tx_status
);
  // Levels move only on request, so the bench always judges settled inputs
  initial begin
    gpio_in = 8'h00;
    rx_status = '0;
    rx_port_en = 4'h0;
    tx_status = '0;
  end
  always @(posedge clk) begin
    if (upd) begin
      gpio_in <= 8'($urandom);
      rx_status <= 32'($urandom);
      rx_port_en <= 4'($urandom);
      tx_status <= 16'($urandom);
    end
  end
endmodule
`default_nettype wire

/* sim/hgp_top_bench.sv */
// Self-checking bench for the general-purpose pin unit
`timescale 1ns/100ps
`default_nettype none
`include "hgp_params.svh"
module hgp_top_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic upd = 1'b0;
  hgp_pkg::hgp_reg_req_s req = '0;
  logic [7:0] rd_data, gpio_in, rdv, en, ctl;
  logic [3:0] rx_port_en;
  hgp_pkg::hgp_rx_port_s [3:0] rx_status;
  hgp_pkg::hgp_tx_port_s [1:0] tx_status;
  logic pin0_out, pin0_oe_n;
  int num_errors = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  hgp_top u_hgp_top (.clk(clk), .srst(srst), .reg_req(req), .rd_data(rd_data),
    .gpio_in(gpio_in), .rx_status(rx_status), .rx_port_en(rx_port_en),
    .tx_status(tx_status), .pin0_out(pin0_out), .pin0_oe_n(pin0_oe_n));
  hgp_board_model u_hgp_board_model (.clk(clk), .upd(upd), .gpio_in(gpio_in),
    .rx_status(rx_status), .rx_port_en(rx_port_en), .tx_status(tx_status));
  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic new_inputs();
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
  endtask
  function automatic logic exp_lvl(input logic [7:0] c);
    logic [2:0] s;
    logic [2:0] k;
    logic [3:0] lk;
    logic [3:0] ps;
    logic [3:0] m;
    s = c[4:2];
    k = c[7:5];
    for (int i = 0; i < 4; i++) begin
      lk[i] = rx_status[i].lock;
      ps[i] = rx_status[i].pass;
    end
    if (s < 3'h4) begin
      case (k)
        3'h4: return rx_status[s[1:0]].lock;
        3'h5: return rx_status[s[1:0]].pass;
        3'h6: return rx_status[s[1:0]].frame_valid;
        3'h7: return rx_status[s[1:0]].line_valid;
        default: return rx_status[s[1:0]].remote_gpio[k[1:0]];
      endcase
    end
    if (s == 3'h5) return 1'b0;
    // Empty port set counts as not locked and not passing
    if (s == 3'h4) begin
      m = rx_port_en;
      case (k)
        3'h0: return c[1];
        3'h1: return |(lk & m);
        3'h2: return (m != 4'h0) && ((lk & m) == m);
        3'h3: return (m != 4'h0) && ((ps & m) == m);
        3'h4: return |(ps & m);
        default: return 1'b0;
      endcase
    end
    m = tx_status[s[0]].rx_map;
    case (k)
      3'h0: return (m != 4'h0) && ((ps & m) == m);
      3'h1: return |(ps & m);
      3'h2: return tx_status[s[0]].frame_valid;
      3'h3: return tx_status[s[0]].line_valid;
      3'h4: return tx_status[s[0]].synced;
      3'h5: return tx_status[s[0]].irq;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    void'($urandom(34));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(`HGP_OFS_INPUT_EN, rdv);
    chk_reg(rdv, 8'hff);
    rd(`HGP_OFS_PIN0_CTL, rdv);
    chk_reg(rdv, 8'h00);
    chk_pin({pin0_out, pin0_oe_n}, 2'h1);
    for (int i = 0; i < 12; i++) begin
      en = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(`HGP_OFS_INPUT_EN, en);
      wr(`HGP_OFS_PIN_STS, 8'($urandom));
      new_inputs();
      rd(`HGP_OFS_INPUT_EN, rdv);
      chk_reg(rdv, en);
      rd(`HGP_OFS_PIN_STS, rdv);
      chk_reg(rdv, gpio_in & en);
    end
    rd(8'h20, rdv);
    chk_reg(rdv, 8'h00);
    for (int i = 0; i < 200; i++) begin
      ctl = (i < 192) ? {i[5:0], 1'($urandom), 1'b1} : 8'($urandom) & 8'hfe;
      wr(`HGP_OFS_PIN0_CTL, ctl);
      new_inputs();
      repeat (2) @(posedge clk);
      #1;
      chk_pin({pin0_out, pin0_oe_n}, ctl[0] ? {exp_lvl(ctl), 1'b0} : 2'h1);
      rd(`HGP_OFS_PIN0_CTL, rdv);
      chk_reg(rdv, ctl);
    end
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire

/* src/hgp_out_mux.sv */
// Source and selector multiplexer for the level offered to pin 0
`timescale 1ns/100ps
`default_nettype none
`include "hgp_params.svh"

module hgp_out_mux (
  input wire logic [7:0] pin_ctl,
  input wire hgp_pkg::hgp_rx_port_s [3:0] rx_status,
  input wire logic [3:0] rx_port_en,
  input wire hgp_pkg::hgp_tx_port_s [1:0] tx_status,
  output logic level
);

  // An empty mask gives low, so no port enabled never reads as all passing
  function automatic logic and_masked(input logic [3:0] mask, input logic [3:0] v);
    and_masked = (|mask) & (&(v | ~mask));
  endfunction

  function automatic logic or_masked(input logic [3:0] mask, input logic [3:0] v);
    or_masked = |(v & mask);
  endfunction

  hgp_pkg::hgp_src_e src;
  logic [2:0] sel;
  logic [3:0] lock_v;
  logic [3:0] pass_v;
  hgp_pkg::hgp_rx_port_s rx;
  hgp_pkg::hgp_tx_port_s tx;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_vec
      assign lock_v[gi] = rx_status[gi].lock;
      assign pass_v[gi] = rx_status[gi].pass;
    end
  endgenerate

  assign src = hgp_pkg::hgp_src_e'(pin_ctl[`HGP_CTL_SRC_MSB:`HGP_CTL_SRC_LSB]);
  assign sel = pin_ctl[`HGP_CTL_SEL_MSB:`HGP_CTL_SEL_LSB];
  assign rx = rx_status[src[1:0]];
  assign tx = tx_status[src[0]];

  always_comb begin
    level = 1'b0;
    case (src)
      hgp_pkg::hgp_src_rx0, hgp_pkg::hgp_src_rx1,
      hgp_pkg::hgp_src_rx2, hgp_pkg::hgp_src_rx3: begin
        case (hgp_pkg::hgp_rx_sel_e'(sel))
          hgp_pkg::hgp_rx_gpio0: level = rx.remote_gpio[0];
          hgp_pkg::hgp_rx_gpio1: level = rx.remote_gpio[1];
          hgp_pkg::hgp_rx_gpio2: level = rx.remote_gpio[2];
          hgp_pkg::hgp_rx_gpio3: level = rx.remote_gpio[3];
          hgp_pkg::hgp_rx_lock: level = rx.lock;
          hgp_pkg::hgp_rx_pass: level = rx.pass;
          hgp_pkg::hgp_rx_fv: level = rx.frame_valid;
          hgp_pkg::hgp_rx_lv: level = rx.line_valid;
          default: level = 1'b0;
        endcase
      end
      hgp_pkg::hgp_src_dev: begin
        case (hgp_pkg::hgp_dev_sel_e'(sel))
          hgp_pkg::hgp_dev_value: level = pin_ctl[`HGP_CTL_VAL_BIT];
          hgp_pkg::hgp_dev_lock_or: level = or_masked(rx_port_en, lock_v);
          hgp_pkg::hgp_dev_lock_and: level = and_masked(rx_port_en, lock_v);
          hgp_pkg::hgp_dev_pass_and: level = and_masked(rx_port_en, pass_v);
          hgp_pkg::hgp_dev_pass_or: level = or_masked(rx_port_en, pass_v);
          default: level = 1'b0;
        endcase
      end
      hgp_pkg::hgp_src_tx0, hgp_pkg::hgp_src_tx1: begin
        case (hgp_pkg::hgp_tx_sel_e'(sel))
          hgp_pkg::hgp_tx_pass_and: level = and_masked(tx.rx_map, pass_v);
          hgp_pkg::hgp_tx_pass_or: level = or_masked(tx.rx_map, pass_v);
          hgp_pkg::hgp_tx_fv: level = tx.frame_valid;
          hgp_pkg::hgp_tx_lv: level = tx.line_valid;
          hgp_pkg::hgp_tx_synced: level = tx.synced;
          hgp_pkg::hgp_tx_irq: level = tx.irq;
          default: level = 1'b0;
        endcase
      end
      default: level = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

/* src/hgp_top.sv */
// General-purpose pin unit: level status, input gating and pin 0 output control
//
// Contract
// - Read-only 8-bit status field returns the level of each pin gated by its input enable; disabled pins read 0.
// - Status bit n holds the level of pin n.
// - One read-write input enable per pin, 1 enables, all reset to 1.
// - Pin 0 control bit 0 enables driving; whole register resets to zero.
// - Control bit 1 is the level driven when register value is selected.
// - Bits 4:2 pick source: receive ports, device status, reserved, transmit ports.
// - Bits 7:5 pick the signal of the chosen source.
// - Receive source: selector 000 gives remote pin 0, 011 remote pin 3.
// - Receive source: 100 lock, 101 pass, 110 frame valid, 111 line valid.
// - Device status offers OR and AND of lock and OR and AND of pass over enabled ports.
// - Transmit source: 000 AND of mapped pass, 001 OR, 010 frame valid.
// - Transmit source: 011 line valid, 100 synchronized, 101 port interrupt.
// - Device status selector 000 drives the register-held output value.
`timescale 1ns/100ps
`default_nettype none
`include "hgp_params.svh"

module hgp_top (
  input wire logic clk,
  input wire logic srst,
  input wire hgp_pkg::hgp_reg_req_s reg_req,
  output logic [7:0] rd_data,
  input wire logic [7:0] gpio_in,
  input wire hgp_pkg::hgp_rx_port_s [3:0] rx_status,
  input wire logic [3:0] rx_port_en,
  input wire hgp_pkg::hgp_tx_port_s [1:0] tx_status,
  output logic pin0_out,
  output logic pin0_oe_n
);

  logic [7:0] pin_level_snapshot;
  logic [7:0] pin_input_enables;
  logic [7:0] pin0_output_control;
  logic [7:0] next_snapshot;
  logic [7:0] next_input_enables;
  logic [7:0] next_output_control;
  logic [7:0] next_rd_data;
  logic next_pin0_out;
  logic next_pin0_oe_n;
  logic mux_level;
  logic pin0_drive_enable;

  function automatic logic [7:0] read_value(input logic [7:0] addr, input logic [7:0] sts,
                                            input logic [7:0] inen, input logic [7:0] ctl);
    case (addr)
      `HGP_OFS_PIN_STS: read_value = sts;
      `HGP_OFS_INPUT_EN: read_value = inen;
      `HGP_OFS_PIN0_CTL: read_value = ctl;
      default: read_value = `HGP_RD_IDLE;
    endcase
  endfunction

  assign pin0_drive_enable = pin0_output_control[`HGP_CTL_EN_BIT];

  hgp_out_mux u_out_mux (
    .pin_ctl(pin0_output_control),
    .rx_status(rx_status),
    .rx_port_en(rx_port_en),
    .tx_status(tx_status),
    .level(mux_level)
  );

  always_comb begin
    // A disabled input reads as low rather than the floating pad level
    next_snapshot = gpio_in & pin_input_enables;
    next_input_enables = pin_input_enables;
    next_output_control = pin0_output_control;
    if (reg_req.wr) begin
      case (reg_req.addr)
        `HGP_OFS_INPUT_EN: next_input_enables = reg_req.wdata;
        `HGP_OFS_PIN0_CTL: next_output_control = reg_req.wdata;
        default: next_input_enables = pin_input_enables;
      endcase
    end
    next_rd_data = `HGP_RD_IDLE;
    if (reg_req.rd) begin
      next_rd_data = read_value(reg_req.addr, pin_level_snapshot, pin_input_enables,
                                pin0_output_control);
    end
    // Released pin is also held low so no stale level leaks when re-enabled
    next_pin0_out = pin0_drive_enable & mux_level;
    next_pin0_oe_n = ~pin0_drive_enable;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_level_snapshot <= `HGP_RST_PIN_STS;
      pin_input_enables <= `HGP_RST_INPUT_EN;
      pin0_output_control <= `HGP_RST_PIN0_CTL;
      rd_data <= `HGP_RD_IDLE;
      pin0_out <= 1'b0;
      pin0_oe_n <= 1'b1;
    end else begin
      pin_level_snapshot <= next_snapshot;
      pin_input_enables <= next_input_enables;
      pin0_output_control <= next_output_control;
      rd_data <= next_rd_data;
      pin0_out <= next_pin0_out;
      pin0_oe_n <= next_pin0_oe_n;
    end
  end

  // Checks
  logic [2:0] chk_src;
  logic [2:0] chk_sel;
  logic chk_rx_gpio;
  logic chk_rx_lock;
  logic chk_dev_lock_or;
  logic chk_tx_fv;

  assign chk_src = pin0_output_control[`HGP_CTL_SRC_MSB:`HGP_CTL_SRC_LSB];
  assign chk_sel = pin0_output_control[`HGP_CTL_SEL_MSB:`HGP_CTL_SEL_LSB];
  assign chk_rx_gpio = rx_status[chk_src[1:0]].remote_gpio[chk_sel[1:0]];
  assign chk_rx_lock = rx_status[chk_src[1:0]].lock;
  assign chk_dev_lock_or = |({rx_status[3].lock, rx_status[2].lock, rx_status[1].lock,
                              rx_status[0].lock} & rx_port_en);
  assign chk_tx_fv = tx_status[chk_src[0]].frame_valid;

  // Second, independent view of the selected port and source class for the mux checks
  logic [3:0] chk_lock_v;
  logic [3:0] chk_pass_v;
  hgp_pkg::hgp_rx_port_s chk_rx;
  hgp_pkg::hgp_tx_port_s chk_tx;
  logic chk_rx_src;
  logic chk_dev_src;
  logic chk_tx_src;

  genvar cj;
  generate
    for (cj = 0; cj < 4; cj++) begin : g_chk
      assign chk_lock_v[cj] = rx_status[cj].lock;
      assign chk_pass_v[cj] = rx_status[cj].pass;
    end
  endgenerate

  assign chk_rx = rx_status[chk_src[1:0]];
  assign chk_tx = tx_status[chk_src[0]];
  assign chk_rx_src = pin0_drive_enable && !chk_src[2];
  assign chk_dev_src = pin0_drive_enable && chk_src == 3'h4;
  assign chk_tx_src = pin0_drive_enable && chk_src[2:1] == 2'h3;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  status_read_a: assert property (
    (reg_req.rd && reg_req.addr == `HGP_OFS_PIN_STS) |=>
      rd_data == ($past(gpio_in, 2) & $past(pin_input_enables, 2)))
    else $error("status read does not show gated pin levels");
  status_bits_a: assert property (
    pin_level_snapshot == ($past(gpio_in) & $past(pin_input_enables)))
    else $error("status bit does not follow its own pin");
  inen_reset_a: assert property (
    $past(srst) |-> pin_input_enables == `HGP_RST_INPUT_EN && pin0_oe_n)
    else $error("reset values of enables wrong");
  oe_follow_a: assert property (
    !pin0_drive_enable ##1 !pin0_drive_enable |-> pin0_oe_n && !pin0_out)
    else $error("pin 0 driven while output disabled");
  reg_value_a: assert property (
    (pin0_drive_enable && chk_src == 3'h4 && chk_sel == 3'h0) |=>
      !pin0_oe_n && pin0_out == $past(pin0_output_control[`HGP_CTL_VAL_BIT]))
    else $error("register value not driven on pin 0");
  rx_gpio_a: assert property (
    (pin0_drive_enable && !chk_src[2] && !chk_sel[2]) |=> pin0_out == $past(chk_rx_gpio))
    else $error("remote pin value not forwarded");
  rx_lock_a: assert property (
    (pin0_drive_enable && !chk_src[2] && chk_sel == 3'h4) |=> pin0_out == $past(chk_rx_lock))
    else $error("receive lock not forwarded");
  dev_lock_or_a: assert property (
    (pin0_drive_enable && chk_src == 3'h4 && chk_sel == 3'h1) |=>
      pin0_out == $past(chk_dev_lock_or))
    else $error("lock OR over enabled ports wrong");
  tx_fv_a: assert property (
    (pin0_drive_enable && chk_src[2:1] == 2'h3 && chk_sel == 3'h2) |=>
      pin0_out == $past(chk_tx_fv))
    else $error("transmit frame valid not forwarded");
  reserved_low_a: assert property (
    (chk_src == 3'h5) [*2] |-> !pin0_out)
    else $error("reserved source drives high");
  ctl_write_a: assert property (
    (reg_req.wr && reg_req.addr == `HGP_OFS_PIN0_CTL) |=>
      pin0_output_control == $past(reg_req.wdata) ##1 pin0_oe_n == !$past(reg_req.wdata[0], 2))
    else $error("control write not applied to pin 0");
  inen_write_a: assert property (
    (reg_req.wr && reg_req.addr == `HGP_OFS_INPUT_EN) |=>
      pin_input_enables == $past(reg_req.wdata))
    else $error("input enable write not applied");
  inen_read_a: assert property (
    (reg_req.rd && reg_req.addr == `HGP_OFS_INPUT_EN) |=>
      rd_data == $past(pin_input_enables))
    else $error("input enable read wrong");
  ctl_read_a: assert property (
    (reg_req.rd && reg_req.addr == `HGP_OFS_PIN0_CTL) |=>
      rd_data == $past(pin0_output_control))
    else $error("pin 0 control read wrong");
  sts_ro_a: assert property (
    (reg_req.wr && reg_req.addr == `HGP_OFS_PIN_STS) |=>
      pin_input_enables == $past(pin_input_enables) &&
      pin0_output_control == $past(pin0_output_control))
    else $error("write to status register changed a control register");
  drive_on_a: assert property (
    pin0_drive_enable |=> !pin0_oe_n)
    else $error("pin 0 not driven while output enabled");
  out_gated_a: assert property (
    pin0_oe_n |-> !pin0_out)
    else $error("pin 0 level high while released");
  rx_mid_pins_a: assert property (
    (chk_rx_src && (chk_sel == 3'h1 || chk_sel == 3'h2)) |=>
      pin0_out == $past(chk_rx.remote_gpio[chk_sel[1:0]]))
    else $error("remote pin 1 or 2 not forwarded");
  rx_pass_a: assert property (
    (chk_rx_src && chk_sel == 3'h5) |=> pin0_out == $past(chk_rx.pass))
    else $error("receive pass not forwarded");
  rx_fv_a: assert property (
    (chk_rx_src && chk_sel == 3'h6) |=> pin0_out == $past(chk_rx.frame_valid))
    else $error("receive frame valid not forwarded");
  rx_lv_a: assert property (
    (chk_rx_src && chk_sel == 3'h7) |=> pin0_out == $past(chk_rx.line_valid))
    else $error("receive line valid not forwarded");
  dev_lock_and_a: assert property (
    (chk_dev_src && chk_sel == 3'h2) |=>
      pin0_out == $past((|rx_port_en) && ((chk_lock_v & rx_port_en) == rx_port_en)))
    else $error("lock AND over enabled ports wrong");
  dev_pass_and_a: assert property (
    (chk_dev_src && chk_sel == 3'h3) |=>
      pin0_out == $past((|rx_port_en) && ((chk_pass_v & rx_port_en) == rx_port_en)))
    else $error("pass AND over enabled ports wrong");
  dev_pass_or_a: assert property (
    (chk_dev_src && chk_sel == 3'h4) |=> pin0_out == $past(|(chk_pass_v & rx_port_en)))
    else $error("pass OR over enabled ports wrong");
  dev_spare_low_a: assert property (
    (chk_dev_src && chk_sel > 3'h4) |=> !pin0_out)
    else $error("unused device status selector drives high");
  tx_pass_and_a: assert property (
    (chk_tx_src && chk_sel == 3'h0) |=>
      pin0_out == $past((|chk_tx.rx_map) && ((chk_pass_v & chk_tx.rx_map) == chk_tx.rx_map)))
    else $error("transmit pass AND wrong");
  tx_pass_or_a: assert property (
    (chk_tx_src && chk_sel == 3'h1) |=> pin0_out == $past(|(chk_pass_v & chk_tx.rx_map)))
    else $error("transmit pass OR wrong");
  tx_lv_a: assert property (
    (chk_tx_src && chk_sel == 3'h3) |=> pin0_out == $past(chk_tx.line_valid))
    else $error("transmit line valid not forwarded");
  tx_synced_a: assert property (
    (chk_tx_src && chk_sel == 3'h4) |=> pin0_out == $past(chk_tx.synced))
    else $error("transmit synchronized flag not forwarded");
  tx_irq_a: assert property (
    (chk_tx_src && chk_sel == 3'h5) |=> pin0_out == $past(chk_tx.irq))
    else $error("transmit interrupt not forwarded");
  tx_spare_low_a: assert property (
    (chk_tx_src && chk_sel[2:1] == 2'h3) |=> !pin0_out)
    else $error("unused transmit selector drives high");

  drive_cov: cover property (!pin0_drive_enable ##1 pin0_drive_enable ##1 !pin0_oe_n);
  rx_src_cov: cover property (pin0_drive_enable && !chk_src[2] && chk_sel == 3'h7 ##1 pin0_out);
  tx_irq_cov: cover property (pin0_drive_enable && chk_src[2:1] == 2'h3 && chk_sel == 3'h5);
  inen_off_cov: cover property (pin_input_enables != `HGP_RST_INPUT_EN && gpio_in != 8'h00);
  dev_pass_cov: cover property (chk_dev_src && chk_sel == 3'h3 ##1 pin0_out);

endmodule

`default_nettype wire
